// file: iobm_host_model.sv
// host board and main memory model for the bus master sequencer
`timescale 1ns/1ps
module iobm_host_model (
    input wire logic core_clk_i, // clock
    input wire logic sys_rst_i, // reset
    input wire logic shared_req_n_i, // wired request line
    input wire logic busy_n_i, // wired busy line
    input wire logic strobe_n_i, // master address strobe
    input wire logic [7:0] grant_dly_i, // cycles before grant
    input wire logic [7:0] ack_dly_i, // cycles before answer
    input wire logic fault_i, // answer with fault
    input wire logic [iobm_pkg::DATA_W-1:0] data_i, // memory word
    output logic grant_n_o, // bus grant
    output logic ack_n_o, // transfer acknowledge
    output logic fault_n_o, // bus fault
    output logic [iobm_pkg::DATA_W-1:0] data_o // bus data
);
    import iobm_pkg::*;
    logic [7:0] gcnt_reg;
    logic [7:0] acnt_reg;
    logic answer_reg;
    logic [DATA_W-1:0] junk_reg;
    // ************************************************
    // arbiter and memory answer
    // ************************************************
    // grant only a pending request; withdrawn once the bus is taken
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || shared_req_n_i) begin
            gcnt_reg <= 8'h00;
            grant_n_o <= 1'b1;
        end else if (!busy_n_i) begin
            grant_n_o <= 1'b1;
        end else if (gcnt_reg >= grant_dly_i) begin
            grant_n_o <= 1'b0;
        end else begin
            gcnt_reg <= gcnt_reg + 8'h01;
        end
    end
    // answer held until the master drops its strobes
    always_ff @(posedge core_clk_i) begin
        junk_reg <= sys_rst_i ? 16'h5A3C : ~data_o;
        if (sys_rst_i || strobe_n_i) begin
            acnt_reg <= 8'h00;
            answer_reg <= 1'b0;
        end else if (acnt_reg >= ack_dly_i) begin
            answer_reg <= 1'b1;
        end else begin
            acnt_reg <= acnt_reg + 8'h01;
        end
    end
    assign ack_n_o = !(answer_reg && !fault_i);
    assign fault_n_o = !(answer_reg && fault_i);
    // released data lines flip every cycle
    assign data_o = answer_reg ? data_i : junk_reg;
endmodule

// file: iobm_pkg.sv
// package of shared constants and types for the bus master sequencer
package iobm_pkg;

    // ************************************************
    // widths
    // ************************************************
    localparam int PAGE_W = 7;
    localparam int LADDR_W = 16;
    localparam int BUS_ADDR_W = 23;
    localparam int DATA_W = 16;

    // ************************************************
    // reset values and timing
    // ************************************************
    localparam logic INACTIVE_N = 1'b1;
    localparam logic [PAGE_W-1:0] PAGE_RESET = 7'h00;
    localparam int CLK_PERIOD_NS = 40;
    localparam int REQ_RELEASE_NS = 100;
    localparam int REQ_RELEASE_CYC =
        (REQ_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES = 3;

    // ************************************************
    // sequencer states
    // ************************************************
    typedef enum logic [3:0] {
        IOBM_IDLE, IOBM_RW1, IOBM_RW2, IOBM_RW3, IOBM_RW4,
        IOBM_RW5, IOBM_RW6, IOBM_RW7, IOBM_TMO
    } iobm_state_t;

    // ************************************************
    // bus side outputs
    // ************************************************
    typedef struct packed {
        logic [BUS_ADDR_W-1:0] addr;
        logic upper_strobe_n;
        logic lower_strobe_n;
        logic bus_busy_n;
        logic bus_addr_strobe_n;
    } iobm_bus_out_t;

endpackage

// file: iobm_seq.sv
// bus master access sequencer: local window accesses to host memory
`timescale 1ns/1ps
module iobm_seq
    import iobm_pkg::*;
(
    input wire logic core_clk_i, // cpu_out_clock, 25 MHz nominal
    input wire logic sys_rst_i, // synchronous reset
    input wire logic window_select_n_i, // combined mid range selects
    input wire logic shared_bus_request_n_i, // shared request line
    input wire logic grant_chain_in_n_i, // incoming bus grant
    input wire logic host_access_n_i, // host access of peripheral
    input wire logic intr_ack_seen_n_i, // interrupt acknowledge
    input wire logic bus_timer_expired_n_i, // processor bus timer
    input wire logic transfer_ack_n_i, // host acknowledge
    input wire logic bus_fault_n_i, // host fault
    input wire logic bus_busy_in_n_i, // shared busy line
    input wire logic byte_high_enable_n_i, // processor byte high
    input wire logic addr_bit0_i, // processor lowest address bit
    input wire logic [iobm_pkg::LADDR_W-1:0] local_addr_i, // word address
    input wire logic [iobm_pkg::PAGE_W-1:0] page_i, // page register
    input wire logic local_read_n_i, // processor read strobe
    input wire logic local_write_n_i, // processor write strobe
    input wire logic host_read_not_write_i, // host direction
    input wire logic host_strobes_any_n_i, // host data strobes combined
    input wire logic dma_want_i, // dma controller wants start
    input wire logic [iobm_pkg::DATA_W-1:0] bus_data_i, // shared bus data
    output logic local_bus_request_n_o, // own bus request
    output logic grant_chain_out_n_o, // downstream grant
    output logic addr_out_enable_n_o, // address and control enable
    output logic on_bus_n_o, // on bus indication
    output logic strobe_out_n_o, // strobe output
    output iobm_pkg::iobm_bus_out_t bus_o, // address and strobes
    output logic data_out_enable_n_o, // transceiver enable
    output logic [iobm_pkg::DATA_W-1:0] read_data_o, // latched read data
    output logic dummy_read_flag_o, // dummy read pending
    output logic dma_request_o // start request to dma
);
    import iobm_pkg::*;

    // ************************************************
    // input synchronisation
    // ************************************************
    logic win_s, sreq_s, grant_s, host_s, iak_s, tmo_s, ack_s, flt_s;
    logic busy_s;
    logic [8:0] async_in;
    logic [8:0] sync_out;
    assign async_in = {window_select_n_i, shared_bus_request_n_i,
        grant_chain_in_n_i, host_access_n_i, intr_ack_seen_n_i,
        bus_timer_expired_n_i, transfer_ack_n_i, bus_fault_n_i,
        bus_busy_in_n_i};
    genvar gi;
    generate
        for (gi = 0; gi < 9; gi++) begin : g_sync
            iobm_sync #(.RESET_VAL(INACTIVE_N)) u_sync (
                .core_clk_i(core_clk_i),
                .sys_rst_i(sys_rst_i),
                .async_i(async_in[gi]),
                .sync_o(sync_out[gi])
            );
        end
    endgenerate
    assign {win_s, sreq_s, grant_s, host_s, iak_s, tmo_s, ack_s, flt_s,
        busy_s} = sync_out;

    // ************************************************
    // registers
    // ************************************************
    iobm_state_t state_reg, state_next;
    logic req_n_reg, req_n_next;
    logic aoe_n_reg, aoe_n_next;
    logic strb_n_reg, strb_n_next;
    logic dummy_reg, dummy_next;
    logic on_bus_n_reg;
    logic ready_raw_reg;
    logic ready_sync_reg;
    logic dma_reg;

    // ************************************************
    // sequencer next state
    // ************************************************
    wire win_act = !win_s;
    wire grant = !grant_s;
    wire ready_sync = ready_sync_reg;

    always_comb begin
        state_next = state_reg;
        req_n_next = req_n_reg;
        aoe_n_next = aoe_n_reg;
        strb_n_next = strb_n_reg;
        dummy_next = dummy_reg;
        case (state_reg)
            IOBM_IDLE: begin
                req_n_next = INACTIVE_N;
                aoe_n_next = INACTIVE_N;
                strb_n_next = INACTIVE_N;
                if (win_act && sreq_s) begin
                    state_next = IOBM_RW1;
                    req_n_next = 1'b0;
                end
            end
            IOBM_RW1: begin
                if (grant) begin
                    state_next = IOBM_RW2;
                    aoe_n_next = 1'b0;
                end else if (!host_s || !iak_s) begin
                    state_next = IOBM_IDLE;
                    req_n_next = INACTIVE_N;
                end else if (!tmo_s) begin
                    state_next = IOBM_TMO;
                    dummy_next = 1'b1;
                end
            end
            IOBM_TMO: begin
                if (grant) begin
                    state_next = IOBM_RW2;
                    aoe_n_next = 1'b0;
                end
            end
            IOBM_RW2: state_next = IOBM_RW3;
            IOBM_RW3: begin
                state_next = IOBM_RW4;
                strb_n_next = 1'b0;
            end
            IOBM_RW4: begin
                if (!grant) begin
                    state_next = IOBM_RW5;
                    req_n_next = INACTIVE_N;
                end
            end
            IOBM_RW5: state_next = IOBM_RW6;
            IOBM_RW6: begin
                if (ready_sync) begin
                    state_next = IOBM_RW7;
                    strb_n_next = INACTIVE_N;
                end
            end
            IOBM_RW7: begin
                aoe_n_next = INACTIVE_N;
                dummy_next = 1'b0;
                if (!ready_sync) begin
                    state_next = IOBM_IDLE;
                end
            end
            default: state_next = IOBM_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_reg <= IOBM_IDLE;
            req_n_reg <= INACTIVE_N;
            aoe_n_reg <= INACTIVE_N;
            strb_n_reg <= INACTIVE_N;
            dummy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            req_n_reg <= req_n_next;
            aoe_n_reg <= aoe_n_next;
            strb_n_reg <= strb_n_next;
            dummy_reg <= dummy_next;
        end
    end

    // ************************************************
    // on bus and ready
    // ************************************************
    wire ack_or_fault = !ack_s || !flt_s;
    // taken from the next value so on-bus falls together with address enable
    wire on_bus_set = !aoe_n_next;
    wire on_bus_clr = !win_act && !dummy_reg;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            on_bus_n_reg <= INACTIVE_N;
            ready_raw_reg <= 1'b0;
            ready_sync_reg <= 1'b0;
            dma_reg <= 1'b0;
        end else begin
            if (on_bus_set) begin
                on_bus_n_reg <= 1'b0;
            end else if (on_bus_clr) begin
                on_bus_n_reg <= INACTIVE_N;
            end
            // held until select and on-bus are both gone
            if (!on_bus_n_reg && ack_or_fault) begin
                ready_raw_reg <= 1'b1;
            end else if (on_bus_n_reg) begin
                ready_raw_reg <= 1'b0;
            end
            ready_sync_reg <= ready_raw_reg;
            dma_reg <= dma_want_i && busy_s;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign local_bus_request_n_o = req_n_reg;
    assign grant_chain_out_n_o = grant_chain_in_n_i || !req_n_reg;
    assign addr_out_enable_n_o = aoe_n_reg;
    assign on_bus_n_o = on_bus_n_reg;
    assign strobe_out_n_o = strb_n_reg;
    assign dummy_read_flag_o = dummy_reg;
    assign dma_request_o = dma_reg;
    assign bus_o.addr = {page_i, local_addr_i};
    assign bus_o.upper_strobe_n = strb_n_reg || byte_high_enable_n_i;
    assign bus_o.lower_strobe_n = strb_n_reg || addr_bit0_i;
    assign bus_o.bus_busy_n = strb_n_reg;
    assign bus_o.bus_addr_strobe_n = strb_n_reg;

    iobm_txdata #(.W(DATA_W)) u_txdata (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .ready_raw_i(ready_raw_reg),
        .bus_data_i(bus_data_i),
        .local_read_n_i(local_read_n_i),
        .local_write_n_i(local_write_n_i),
        .on_bus_n_i(on_bus_n_reg),
        .addr_out_enable_n_i(aoe_n_reg),
        .host_access_n_i(host_s),
        .intr_ack_seen_n_i(iak_s),
        .host_read_not_write_i(host_read_not_write_i),
        .host_strobes_any_n_i(host_strobes_any_n_i),
        .dummy_read_flag_i(dummy_reg),
        .data_out_enable_n_o(data_out_enable_n_o),
        .read_data_o(read_data_o)
    );

    // ************************************************
    // checks
    // ************************************************
    a_strobe_after_aoe: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        $fell(aoe_n_reg) |-> ##2 $fell(strb_n_reg))
        else $error("strobe not two clocks after address enable");
    a_aoe_after_strobe: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        $rose(strb_n_reg) |-> ##1 aoe_n_reg)
        else $error("address enable not dropped after strobe");
    a_req_before_strb: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        $rose(strb_n_reg) |-> $past(req_n_reg, 2))
        else $error("request not released before strobe end");
    a_idle_quiet: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (state_reg == IOBM_IDLE) |-> (strb_n_reg && aoe_n_reg))
        else $error("outputs active in idle");
    a_no_req_shared: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        ($fell(req_n_reg) && state_reg == IOBM_RW1) |->
            $past(sreq_s))
        else $error("request while shared request active");
    a_grant_blocked: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        !req_n_reg |-> grant_chain_out_n_o)
        else $error("grant passed while requesting");
    a_rel_on_drop: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (state_reg == IOBM_RW4 && !grant) |-> ##1 req_n_reg)
        else $error("request held after grant drop");
    a_dma_busy: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        !busy_s |-> ##1 !dma_reg)
        else $error("dma started while bus busy");
endmodule

// file: iobm_sync.sv
// three stage input synchroniser with agreement filter
`timescale 1ns/1ps
module iobm_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic core_clk_i, // clock
    input wire logic sys_rst_i, // synchronous reset
    input wire logic async_i, // input from outside the domain
    output logic sync_o // filtered synchronised level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic out_reg;
    wire agree = (s2_reg == s3_reg);

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            s1_reg <= RESET_VAL;
            s2_reg <= RESET_VAL;
            s3_reg <= RESET_VAL;
            out_reg <= RESET_VAL;
        end else begin
            s1_reg <= async_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (agree) begin
                out_reg <= s3_reg;
            end
        end
    end

    assign sync_o = out_reg;
endmodule

// file: iobm_txdata.sv
// data transceiver latch and enable logic
`timescale 1ns/1ps
module iobm_txdata
    import iobm_pkg::*;
#(
    parameter int W = DATA_W
) (
    input wire logic core_clk_i, // clock
    input wire logic sys_rst_i, // synchronous reset
    input wire logic ready_raw_i, // unsynchronised ready
    input wire logic [W-1:0] bus_data_i, // data from shared bus
    input wire logic local_read_n_i, // local read active
    input wire logic local_write_n_i, // local write active
    input wire logic on_bus_n_i, // on bus indication
    input wire logic addr_out_enable_n_i, // address enable
    input wire logic host_access_n_i, // host access of peripheral
    input wire logic intr_ack_seen_n_i, // interrupt acknowledge
    input wire logic host_read_not_write_i, // host direction
    input wire logic host_strobes_any_n_i, // host strobes combined
    input wire logic dummy_read_flag_i, // dummy read in progress
    output logic data_out_enable_n_o, // transceiver enable
    output logic [W-1:0] read_data_o // latched read data
);
    logic [W-1:0] data_reg;
    logic ready_q_reg;

    // four sources of the transceiver enable
    wire src_lrd = !local_read_n_i && !on_bus_n_i;
    wire src_lwr = !local_write_n_i && !addr_out_enable_n_i;
    wire src_hrd = !host_access_n_i && host_read_not_write_i;
    wire src_iak = !intr_ack_seen_n_i && host_read_not_write_i;
    wire host_drv = (src_hrd || src_iak) && !host_strobes_any_n_i;
    wire local_drv = (src_lrd || src_lwr) && !dummy_read_flag_i;
    assign data_out_enable_n_o = !(host_drv || local_drv);

    // rising ready captures read data so the bus can be left early
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ready_q_reg <= 1'b0;
            data_reg <= '0;
        end else begin
            ready_q_reg <= ready_raw_i;
            if (ready_raw_i && !ready_q_reg) begin
                data_reg <= bus_data_i;
            end
        end
    end
    assign read_data_o = data_reg;

    a_no_host_write: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (!host_access_n_i && !host_read_not_write_i && local_read_n_i &&
         local_write_n_i) |-> data_out_enable_n_o)
        else $error("data driven during host write");
    a_rd_strobe_hold: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (!local_read_n_i && !on_bus_n_i && !dummy_read_flag_i)
        |-> !data_out_enable_n_o)
        else $error("read enable dropped early");
endmodule

// file: tb_top.sv
// self-checking bench for the bus master access sequencer
`timescale 1ns/1ps
module tb_top;
    import iobm_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sel_n = 1'b1, oreq_n = 1'b1, obusy_n = 1'b1, hacc_n = 1'b1;
    logic iack_n = 1'b1, tmr_n = 1'b1, bhe_n = 1'b1, a0 = 1'b0;
    logic rd_n = 1'b1, wr_n = 1'b1, hrnw = 1'b0, hstrb_n = 1'b1;
    logic dma_want = 1'b0, fault = 1'b0;
    logic [15:0] laddr = 16'h0000, hdata = 16'h0000, rdata, bdata;
    logic [6:0] page = 7'h00;
    logic [7:0] gdly = 8'h00, adly = 8'h00;
    logic req_n, gout_n, aoe_n, onb_n, strb_n, deoe_n, dummy, dmareq;
    logic grant_n, ack_n, flt_n, hs_any_n;
    iobm_bus_out_t bus;
    logic [31:0] seed = 32'h2F36F2DA;
    int failures = 0;
    int cmp_count = 0;
    assign hs_any_n = bus.upper_strobe_n & bus.lower_strobe_n & hstrb_n;

    iobm_seq i_dut (
        .core_clk_i(clk), .sys_rst_i(rst), .window_select_n_i(sel_n),
        .shared_bus_request_n_i(req_n & oreq_n),
        .grant_chain_in_n_i(grant_n), .host_access_n_i(hacc_n),
        .intr_ack_seen_n_i(iack_n), .bus_timer_expired_n_i(tmr_n),
        .transfer_ack_n_i(ack_n), .bus_fault_n_i(flt_n),
        .bus_busy_in_n_i(bus.bus_busy_n & obusy_n),
        .byte_high_enable_n_i(bhe_n), .addr_bit0_i(a0),
        .local_addr_i(laddr), .page_i(page), .local_read_n_i(rd_n),
        .local_write_n_i(wr_n), .host_read_not_write_i(hrnw),
        .host_strobes_any_n_i(hs_any_n), .dma_want_i(dma_want),
        .bus_data_i(bdata), .local_bus_request_n_o(req_n),
        .grant_chain_out_n_o(gout_n), .addr_out_enable_n_o(aoe_n),
        .on_bus_n_o(onb_n), .strobe_out_n_o(strb_n), .bus_o(bus),
        .data_out_enable_n_o(deoe_n), .read_data_o(rdata),
        .dummy_read_flag_o(dummy), .dma_request_o(dmareq)
    );
    iobm_host_model i_host (
        .core_clk_i(clk), .sys_rst_i(rst), .shared_req_n_i(req_n & oreq_n),
        .busy_n_i(bus.bus_busy_n & obusy_n), .strobe_n_i(bus.bus_addr_strobe_n),
        .grant_dly_i(gdly), .ack_dly_i(adly), .fault_i(fault),
        .data_i(hdata), .grant_n_o(grant_n), .ack_n_o(ack_n),
        .fault_n_o(flt_n), .data_o(bdata)
    );

    initial begin
        forever #20 clk = ~clk;
    end
    // ************************************************
    // helpers
    // ************************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic sig(input int k);
        case (k)
            0: return req_n;
            1: return aoe_n;
            2: return strb_n;
            3: return onb_n;
            4: return dummy;
            default: return dmareq;
        endcase
    endfunction
    task automatic fail_msg(input string msg);
        failures++;
        $display("ERROR at %0t: %s", $time, msg);
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string m);
        cmp_count++;
        if (got !== exp) fail_msg(m);
    endtask
    task automatic chk_vec(input logic [22:0] got, input logic [22:0] exp,
                           input string m);
        cmp_count++;
        if (got !== exp) fail_msg(m);
    endtask
    task automatic wait_for(input int k, input logic v, input int lim,
                            output int n);
        n = 0;
        while (sig(k) !== v && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (sig(k) !== v) fail_msg("wait expired");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // one local access: r packs direction, lanes, fault, delays, address
    task automatic access(input logic [31:0] r, input logic [15:0] d);
        int n;
        @(posedge clk);
        rd_n <= !r[0];
        wr_n <= r[0];
        bhe_n <= r[1];
        a0 <= r[2] & !r[1];
        fault <= r[3];
        gdly <= {4'h0, r[7:4]};
        adly <= {5'h00, r[10:8]};
        page <= {2'b00, r[15:11]};
        laddr <= r[31:16];
        hdata <= d;
        sel_n <= 1'b0;
        wait_for(0, 1'b0, 16, n);
        wait_for(1, 1'b0, 60, n);
        chk_bit(onb_n, 1'b0, "on-bus");
        wait_for(2, 1'b0, 4, n);
        chk_vec(23'(n), 23'h2, "strobe delay");
        chk_vec(bus.addr, {page, laddr}, "address");
        chk_bit(bus.upper_strobe_n, bhe_n, "upper lane");
        chk_bit(bus.lower_strobe_n, a0, "lower lane");
        chk_bit(bus.bus_busy_n | bus.bus_addr_strobe_n, 1'b0, "busy");
        chk_bit(gout_n, 1'b1, "grant blocked");
        if (!r[0]) chk_bit(deoe_n, 1'b0, "write enable");
        wait_for(2, 1'b1, 300, n);
        chk_bit(ack_n & flt_n, 1'b0, "strobe before ready");
        chk_bit(req_n, 1'b1, "request released");
        chk_bit(aoe_n, 1'b0, "aoe hold");
        @(posedge clk);
        #1;
        chk_bit(aoe_n, 1'b1, "aoe off");
        if (r[0] && !r[3]) chk_vec(23'(rdata), 23'(d), "read data");
        if (r[0]) chk_bit(deoe_n, 1'b0, "read enable");
        @(posedge clk);
        sel_n <= 1'b1;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        #1;
        chk_bit(deoe_n, 1'b1, "enable off");
        wait_for(3, 1'b1, 12, n);
        repeat (8) @(posedge clk);
        #1;
        chk_bit(req_n, 1'b1, "single tenure");
    endtask
    // ************************************************
    // tests
    // ************************************************
    initial begin
        repeat (20000) @(posedge clk);
        fail_msg("watchdog expired");
        tally_and_finish();
    end
    initial begin
        int n;
        logic [31:0] r32;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk_bit(req_n & aoe_n & onb_n & strb_n & deoe_n, 1'b1, "idle");
        chk_bit(dummy | dmareq | !bus.bus_busy_n, 1'b0, "flags");
        chk_vec(23'(rdata), 23'h0, "read data reset");
        $display("test reset finished");
        access(32'hFFFFF805, 16'hA5C3);
        access(32'h00000002, 16'h0000);
        $display("test corners finished");
        @(posedge clk);
        oreq_n <= 1'b0;
        sel_n <= 1'b0;
        repeat (12) @(posedge clk);
        #1;
        chk_bit(req_n, 1'b1, "shared request active");
        chk_bit(gout_n | grant_n, 1'b0, "grant passes on");
        @(posedge clk);
        oreq_n <= 1'b1;
        sel_n <= 1'b1;
        repeat (8) @(posedge clk);
        access(32'h12340031, 16'h5AA5);
        $display("test arbitration finished");
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            gdly <= 8'hC8;
            sel_n <= 1'b0;
            wait_for(0, 1'b0, 16, n);
            @(posedge clk);
            hacc_n <= k[0];
            iack_n <= !k[0];
            sel_n <= 1'b1;
            wait_for(0, 1'b1, 12, n);
            chk_bit(aoe_n, 1'b1, "abort");
            @(posedge clk);
            hacc_n <= 1'b1;
            iack_n <= 1'b1;
            repeat (8) @(posedge clk);
        end
        $display("test abort finished");
        @(posedge clk);
        gdly <= 8'h50;
        sel_n <= 1'b0;
        rd_n <= 1'b0;
        wait_for(0, 1'b0, 16, n);
        @(posedge clk);
        tmr_n <= 1'b0;
        repeat (6) @(posedge clk);
        tmr_n <= 1'b1;
        sel_n <= 1'b1;
        rd_n <= 1'b1;
        wait_for(4, 1'b1, 12, n);
        chk_bit(dummy & !req_n, 1'b1, "dummy pending");
        wait_for(1, 1'b0, 120, n);
        wait_for(4, 1'b0, 300, n);
        wait_for(3, 1'b1, 20, n);
        chk_bit(req_n & strb_n & aoe_n, 1'b1, "dummy done");
        $display("test timeout finished");
        @(posedge clk);
        hacc_n <= 1'b0;
        hrnw <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk_bit(deoe_n, 1'b1, "host read no strobe");
        hstrb_n <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk_bit(deoe_n, 1'b0, "host read");
        hrnw <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk_bit(deoe_n, 1'b1, "host write");
        hacc_n <= 1'b1;
        hstrb_n <= 1'b1;
        dma_want <= 1'b1;
        obusy_n <= 1'b0;
        repeat (10) @(posedge clk);
        #1;
        chk_bit(dmareq, 1'b0, "dma held");
        obusy_n <= 1'b1;
        wait_for(5, 1'b1, 10, n);
        chk_bit(dmareq, 1'b1, "dma start");
        dma_want <= 1'b0;
        $display("test host and dma finished");
        for (int i = 0; i < 12; i++) begin
            r32 = rnd();
            access(r32, 16'(rnd()));
        end
        $display("test random finished");
        tally_and_finish();
    end
endmodule
